// File: timer8_defs.vh
/*
 * register offsets, field positions, reset values and codes for the 8-bit
 * timer with two compare channels. included by timer8_regs.v.
 */
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// register byte offsets on the axi4-lite bus
`define OFF_CTRL_B      12'h000
`define OFF_COUNT       12'h004
`define OFF_CMP_A       12'h008
`define OFF_CMP_B       12'h00c
`define OFF_IRQ_MASK    12'h010
`define OFF_IRQ_FLAGS   12'h014
`define OFF_CTRL_A      12'h018

// timer_control_b fields
`define CB_FORCE_A      7
`define CB_FORCE_B      6
`define CB_WAVE2        3
`define CB_CS_HI        2
`define CB_CS_LO        0

// timer_control_a fields (output modes and low wave bits)
`define CA_OMA_HI       7
`define CA_OMA_LO       6
`define CA_OMB_HI       5
`define CA_OMB_LO       4
`define CA_WAVE_HI      1
`define CA_WAVE_LO      0

// flag / mask bit positions
`define FLG_OVF         0
`define FLG_MA          1
`define FLG_MB          2

// reset values
`define RST_BYTE        8'h00
`define RST_FLAGS       3'h0

// counter limits
`define CNT_MAX         8'hff
`define CNT_BOTTOM      8'h00

// wave modes
`define WM_NORMAL       3'h0
`define WM_PC_FF        3'h1
`define WM_CTC          3'h2
`define WM_FAST_FF      3'h3
`define WM_PC_A         3'h5
`define WM_FAST_A       3'h7

// clock select codes
`define CS_STOP         3'h0
`define CS_DIV1         3'h1
`define CS_DIV8         3'h2
`define CS_DIV64        3'h3
`define CS_DIV256       3'h4
`define CS_DIV1024      3'h5
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7

// prescaler tap masks
`define PS_MASK8        10'h007
`define PS_MASK64       10'h03f
`define PS_MASK256      10'h0ff
`define PS_MASK1024     10'h3ff

// output mode codes
`define OM_OFF          2'h0
`define OM_TOGGLE       2'h1
`define OM_CLEAR        2'h2
`define OM_SET          2'h3

// axi responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: timer8_regs.v
/*
 * 8-bit timer/counter with two compare channels, overflow and compare flags,
 * interrupt mask and force-compare strobes, reached over axi4-lite.
 * assumes inputs synchronous to I_SYS_CLK, one write and one read at a time.
 */
`timescale 1ns/1ps
`include "timer8_defs.vh"

module timer8_regs
(
    // clock, reset, enable
    input  wire        I_SYS_CLK,
    input  wire        I_SYS_RST,
    input  wire        I_CLK_EN,
    // axi4-lite write address
    input  wire [11:0] I_AWADDR,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    // axi4-lite write data
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    // axi4-lite write response
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    // axi4-lite read address
    input  wire [11:0] I_ARADDR,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    // axi4-lite read data
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    // cpu side interrupt control
    input  wire        I_GLOBAL_IRQ_EN,
    input  wire        I_ACK_OVF,
    input  wire        I_ACK_MATCH_A,
    input  wire        I_ACK_MATCH_B,
    output reg         O_IRQ_OVF,
    output reg         O_IRQ_MATCH_A,
    output reg         O_IRQ_MATCH_B,
    // pins
    input  wire        I_EXT_COUNT_PIN,
    output reg         O_WAVE_OUT_A,
    output reg         O_WAVE_OUT_A_OE,
    output reg         O_WAVE_OUT_B,
    output reg         O_WAVE_OUT_B_OE
);

    // registers
    reg  [7:0] ctrl_a_r;
    reg        wave2_r;
    reg  [2:0] clk_sel_r;
    reg  [7:0] count_r;
    reg  [7:0] cmp_a_r;
    reg  [7:0] cmp_b_r;
    reg  [7:0] cmp_a_buf_r;
    reg  [7:0] cmp_b_buf_r;
    reg  [2:0] irq_mask_r;
    reg  [2:0] flags_r;
    reg        dir_down_r;
    reg        block_r;
    reg  [9:0] presc_r;
    reg        pin_s1_r;
    reg        pin_s2_r;
    reg        pin_s3_r;
    reg        wave_a_r;
    reg        wave_b_r;
    // bus state
    reg        aw_held_r;
    reg        w_held_r;
    reg [11:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg  [3:0] w_strb_r;

    wire [2:0] wave_mode = {wave2_r, ctrl_a_r[`CA_WAVE_HI:`CA_WAVE_LO]};
    wire [1:0] om_a      = ctrl_a_r[`CA_OMA_HI:`CA_OMA_LO];
    wire [1:0] om_b      = ctrl_a_r[`CA_OMB_HI:`CA_OMB_LO];

    // non-pwm: normal, ctc and the reserved codes
    function is_pwm;
        input [2:0] m;
        begin
            is_pwm = (m == `WM_PC_FF) || (m == `WM_FAST_FF) || (m == `WM_PC_A) || (m == `WM_FAST_A);
        end
    endfunction

    // output action for a match in non-pwm mode
    function apply_om;
        input [1:0] om;
        input       cur;
        begin
            case (om)
                `OM_TOGGLE: apply_om = ~cur;
                `OM_CLEAR:  apply_om = 1'b0;
                `OM_SET:    apply_om = 1'b1;
                default:    apply_om = cur;
            endcase
        end
    endfunction

    wire       top_is_a  = (wave_mode == `WM_CTC) || (wave_mode == `WM_PC_A) || (wave_mode == `WM_FAST_A);
    wire [7:0] top_val   = top_is_a ? cmp_a_r : `CNT_MAX;
    wire       pwm       = is_pwm(wave_mode);
    wire       phase_cor = (wave_mode == `WM_PC_FF) || (wave_mode == `WM_PC_A);

    // counter clock enable
    reg tick;
    always @*
    begin
        case (clk_sel_r)
            `CS_DIV1:     tick = 1'b1;
            `CS_DIV8:     tick = (presc_r & `PS_MASK8) == `PS_MASK8;
            `CS_DIV64:    tick = (presc_r & `PS_MASK64) == `PS_MASK64;
            `CS_DIV256:   tick = (presc_r & `PS_MASK256) == `PS_MASK256;
            `CS_DIV1024:  tick = presc_r == `PS_MASK1024;
            `CS_EXT_FALL: tick = pin_s3_r & ~pin_s2_r;
            `CS_EXT_RISE: tick = ~pin_s3_r & pin_s2_r;
            default:      tick = 1'b0;
        endcase
    end

    // compare matches on counter clock, suppressed after a counter write
    wire match_a = tick & ~block_r & (count_r == cmp_a_r);
    wire match_b = tick & ~block_r & (count_r == cmp_b_r);

    // next count and overflow event
    reg  [7:0] count_nxt;
    reg        dir_nxt;
    reg        ovf_ev;
    always @*
    begin
        count_nxt = count_r;
        dir_nxt   = dir_down_r;
        ovf_ev    = 1'b0;
        if (tick)
        begin
            if (phase_cor)
            begin
                if (!dir_down_r && count_r >= top_val)
                begin
                    dir_nxt   = 1'b1;
                    count_nxt = count_r - 8'h01;
                end
                else if (dir_down_r && count_r == `CNT_BOTTOM)
                begin
                    dir_nxt   = 1'b0;
                    count_nxt = count_r + 8'h01;
                    ovf_ev    = 1'b1;
                end
                else
                    count_nxt = dir_down_r ? count_r - 8'h01 : count_r + 8'h01;
            end
            else if (top_is_a && count_r == top_val)
            begin
                count_nxt = `CNT_BOTTOM;
                // ctc flags overflow at max, fast pwm with compare a top at top
                ovf_ev    = (wave_mode == `WM_FAST_A) || (count_r == `CNT_MAX);
            end
            else
            begin
                count_nxt = count_r + 8'h01;
                ovf_ev    = (count_r == `CNT_MAX);
            end
        end
    end

    // bus write decode
    wire        wr_go   = aw_held_r & w_held_r & ~O_BVALID;
    wire        wr_ok   = (aw_addr_r == `OFF_CTRL_B) || (aw_addr_r == `OFF_COUNT) || (aw_addr_r == `OFF_CMP_A)
                          || (aw_addr_r == `OFF_CMP_B) || (aw_addr_r == `OFF_IRQ_MASK)
                          || (aw_addr_r == `OFF_IRQ_FLAGS) || (aw_addr_r == `OFF_CTRL_A);
    wire        wr_b0   = wr_go & w_strb_r[0];
    wire [7:0]  wd      = w_data_r[7:0];
    wire        wr_cb   = wr_b0 && (aw_addr_r == `OFF_CTRL_B);
    wire        wr_cnt  = wr_b0 && (aw_addr_r == `OFF_COUNT);
    wire        wr_flg  = wr_b0 && (aw_addr_r == `OFF_IRQ_FLAGS);
    wire        force_a = wr_cb & wd[`CB_FORCE_A] & ~pwm;
    wire        force_b = wr_cb & wd[`CB_FORCE_B] & ~pwm;

    // flags: set wins over clear; forced compares excluded
    wire [2:0] flag_set = {match_b, match_a, ovf_ev};
    wire [2:0] flag_clr = (wr_flg ? wd[`FLG_MB:`FLG_OVF] : 3'h0)
                          | {I_ACK_MATCH_B, I_ACK_MATCH_A, I_ACK_OVF};
    wire [2:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;

    // read mux
    reg [7:0] rd_byte;
    reg       rd_ok;
    always @*
    begin
        rd_ok = 1'b1;
        if (I_ARADDR == `OFF_CTRL_B)
            rd_byte = {2'h0, 2'h0, wave2_r, clk_sel_r};
        else if (I_ARADDR == `OFF_COUNT)
            rd_byte = count_r;
        else if (I_ARADDR == `OFF_CMP_A)
            rd_byte = cmp_a_buf_r;
        else if (I_ARADDR == `OFF_CMP_B)
            rd_byte = cmp_b_buf_r;
        else if (I_ARADDR == `OFF_IRQ_MASK)
            rd_byte = {5'h00, irq_mask_r};
        else if (I_ARADDR == `OFF_IRQ_FLAGS)
            rd_byte = {5'h00, flags_r};
        else if (I_ARADDR == `OFF_CTRL_A)
            rd_byte = {ctrl_a_r[`CA_OMA_HI:`CA_OMB_LO], 2'h0, ctrl_a_r[`CA_WAVE_HI:`CA_WAVE_LO]};
        else
        begin
            rd_byte = `RST_BYTE;
            rd_ok   = 1'b0;
        end
    end

    // buffered compare update at top in pwm modes
    wire at_top = tick & (count_r == top_val);
    wire upd_cmp = ~pwm | at_top;

    always @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            ctrl_a_r        <= `RST_BYTE;
            wave2_r         <= 1'b0;
            clk_sel_r       <= `CS_STOP;
            count_r         <= `RST_BYTE;
            cmp_a_r         <= `RST_BYTE;
            cmp_b_r         <= `RST_BYTE;
            cmp_a_buf_r     <= `RST_BYTE;
            cmp_b_buf_r     <= `RST_BYTE;
            irq_mask_r      <= `RST_FLAGS;
            flags_r         <= `RST_FLAGS;
            dir_down_r      <= 1'b0;
            block_r         <= 1'b0;
            presc_r         <= 10'h000;
            pin_s1_r        <= 1'b0;
            pin_s2_r        <= 1'b0;
            pin_s3_r        <= 1'b0;
            wave_a_r        <= 1'b0;
            wave_b_r        <= 1'b0;
            aw_held_r       <= 1'b0;
            w_held_r        <= 1'b0;
            aw_addr_r       <= 12'h000;
            w_data_r        <= 32'h0000_0000;
            w_strb_r        <= 4'h0;
            O_AWREADY       <= 1'b0;
            O_WREADY        <= 1'b0;
            O_BVALID        <= 1'b0;
            O_BRESP         <= `RESP_OKAY;
            O_ARREADY       <= 1'b0;
            O_RVALID        <= 1'b0;
            O_RDATA         <= 32'h0000_0000;
            O_RRESP         <= `RESP_OKAY;
            O_IRQ_OVF       <= 1'b0;
            O_IRQ_MATCH_A   <= 1'b0;
            O_IRQ_MATCH_B   <= 1'b0;
            O_WAVE_OUT_A    <= 1'b0;
            O_WAVE_OUT_A_OE <= 1'b0;
            O_WAVE_OUT_B    <= 1'b0;
            O_WAVE_OUT_B_OE <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            presc_r  <= presc_r + 10'h001;
            pin_s1_r <= I_EXT_COUNT_PIN;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;

            // write channels, taken in either order
            O_AWREADY <= ~aw_held_r & ~O_AWREADY & I_AWVALID;
            O_WREADY  <= ~w_held_r & ~O_WREADY & I_WVALID;
            if (O_AWREADY & I_AWVALID)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {I_AWADDR[11:2], 2'h0};
            end
            if (O_WREADY & I_WVALID)
            begin
                w_held_r <= 1'b1;
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
            end
            if (wr_go)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                O_BVALID  <= 1'b1;
                O_BRESP   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (O_BVALID & I_BREADY)
                O_BVALID <= 1'b0;

            // read channel
            O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
            if (O_ARREADY & I_ARVALID)
            begin
                O_RVALID <= 1'b1;
                O_RDATA  <= {24'h000000, rd_byte};
                O_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (O_RVALID & I_RREADY)
                O_RVALID <= 1'b0;

            // register writes
            if (wr_b0 && aw_addr_r == `OFF_CTRL_A)
                ctrl_a_r <= {wd[`CA_OMA_HI:`CA_OMB_LO], 2'h0, wd[`CA_WAVE_HI:`CA_WAVE_LO]};
            if (wr_cb)
            begin
                wave2_r   <= wd[`CB_WAVE2];
                clk_sel_r <= wd[`CB_CS_HI:`CB_CS_LO];
            end
            if (wr_b0 && aw_addr_r == `OFF_CMP_A)
                cmp_a_buf_r <= wd;
            if (wr_b0 && aw_addr_r == `OFF_CMP_B)
                cmp_b_buf_r <= wd;
            if (wr_b0 && aw_addr_r == `OFF_IRQ_MASK)
                irq_mask_r <= wd[`FLG_MB:`FLG_OVF];
            if (upd_cmp)
            begin
                cmp_a_r <= cmp_a_buf_r;
                cmp_b_r <= cmp_b_buf_r;
            end

            // counter
            if (wr_cnt)
            begin
                count_r <= wd;
                block_r <= 1'b1;
            end
            else
            begin
                count_r <= count_nxt;
                if (tick)
                    block_r <= 1'b0;
            end
            dir_down_r <= dir_nxt;
            flags_r    <= flags_nxt;

            // waveform generation
            if (!pwm)
            begin
                if (force_a | match_a)
                    wave_a_r <= apply_om(om_a, wave_a_r);
                if (force_b | match_b)
                    wave_b_r <= apply_om(om_b, wave_b_r);
            end
            else if (phase_cor)
            begin
                if (match_a)
                    wave_a_r <= om_a[0] ^ dir_down_r;
                if (match_b)
                    wave_b_r <= om_b[0] ^ dir_down_r;
            end
            else
            begin
                if (match_a)
                    wave_a_r <= om_a[0];
                else if (at_top)
                    wave_a_r <= ~om_a[0];
                if (match_b)
                    wave_b_r <= om_b[0];
                else if (at_top)
                    wave_b_r <= ~om_b[0];
            end
            O_WAVE_OUT_A    <= wave_a_r;
            O_WAVE_OUT_A_OE <= om_a != `OM_OFF;
            O_WAVE_OUT_B    <= wave_b_r;
            O_WAVE_OUT_B_OE <= om_b != `OM_OFF;

            // interrupt requests
            O_IRQ_MATCH_B <= irq_mask_r[`FLG_MB] & I_GLOBAL_IRQ_EN & flags_nxt[`FLG_MB];
            O_IRQ_MATCH_A <= irq_mask_r[`FLG_MA] & I_GLOBAL_IRQ_EN & flags_nxt[`FLG_MA];
            O_IRQ_OVF     <= irq_mask_r[`FLG_OVF] & I_GLOBAL_IRQ_EN & flags_nxt[`FLG_OVF];
        end
    end

endmodule

// File: timer8_monitor.sv
/*
 * checker for timer8_regs: bus handshakes, read-back of unused bits, irq gating.
 * assumes it is bound to timer8_regs and that bus masters hold requests until taken.
 */
`timescale 1ns/1ps

module timer8_monitor
(
    // clock, reset, enables
    input wire        I_SYS_CLK,
    input wire        I_SYS_RST,
    input wire        I_CLK_EN,
    input wire        I_GLOBAL_IRQ_EN,
    // write channels
    input wire        I_AWVALID,
    input wire        O_AWREADY,
    input wire        I_WVALID,
    input wire        O_WREADY,
    input wire [1:0]  O_BRESP,
    input wire        O_BVALID,
    input wire        I_BREADY,
    // read channels
    input wire [11:0] I_ARADDR,
    input wire        I_ARVALID,
    input wire        O_ARREADY,
    input wire [31:0] O_RDATA,
    input wire [1:0]  O_RRESP,
    input wire        O_RVALID,
    input wire        I_RREADY,
    // interrupt requests
    input wire        O_IRQ_OVF,
    input wire        O_IRQ_MATCH_A,
    input wire        O_IRQ_MATCH_B
);
    wire rd_take;
    wire wr_take;

    assign rd_take = I_ARVALID && O_ARREADY && I_CLK_EN;
    assign wr_take = I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && I_CLK_EN;

    default clocking @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    bvalid_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response withdrawn early");
    rvalid_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA) && $stable(O_RRESP))
        else $error("read data withdrawn early");
    rvalid_time_a: assert property (rd_take |=> O_RVALID)
        else $error("read data late");
    bvalid_time_a: assert property (wr_take ##1 I_CLK_EN |=> O_BVALID)
        else $error("write response late");
    arready_pulse_a: assert property (O_ARREADY && I_CLK_EN |=> !O_ARREADY)
        else $error("read address ready longer than one cycle");
    rdata_upper_a: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    ctrl_read_a: assert property (rd_take && I_ARADDR == 12'h000 |=> O_RDATA[7:4] == 4'h0)
        else $error("control b strobe or unused bits read nonzero");
    irq_regs_read_a: assert property (rd_take && (I_ARADDR == 12'h010 || I_ARADDR == 12'h014)
        |=> O_RDATA[7:3] == 5'h0)
        else $error("mask or flag unused bits read nonzero");
    slverr_read_a: assert property (rd_take && I_ARADDR >= 12'h01c |=> O_RRESP == 2'h2 && O_RDATA == 32'h0)
        else $error("unmapped read not refused");
    irq_gate_a: assert property ((!I_GLOBAL_IRQ_EN && I_CLK_EN) [*2]
        |-> !O_IRQ_OVF && !O_IRQ_MATCH_A && !O_IRQ_MATCH_B)
        else $error("interrupt raised with global enable off");
endmodule

bind timer8_regs timer8_monitor timer8_monitor_inst
(
    .I_SYS_CLK, .I_SYS_RST, .I_CLK_EN, .I_GLOBAL_IRQ_EN,
    .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY,
    .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY,
    .O_IRQ_OVF, .O_IRQ_MATCH_A, .O_IRQ_MATCH_B
);

// File: test_timer8_regs.sv
/*
 * self-checking bench for timer8_regs: registers over axi4-lite, counting,
 * compare flags, interrupts and forced compares. assumes timer8_monitor is bound.
 */
`timescale 1ns/1ps
`include "timer8_defs.vh"

module test_timer8_regs;
    reg         clk, rst, en, awvalid, wvalid, bready, arvalid, rready;
    reg         gie, ack_ovf, ack_a, ack_b, ext_pin;
    reg  [11:0] awaddr, araddr;
    reg  [31:0] wdata, d;
    wire        awready, wready, bvalid, arready, rvalid, irq_ovf, irq_a, irq_b;
    wire        wave_a, wave_a_oe, wave_b, wave_b_oe;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     failures, n_checks, k;
    integer     divs [1:5] = '{1, 8, 64, 256, 1024};
    reg  [11:0] a;

    timer8_regs timer8_regs_inst
    (
        .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(en),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
        .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid), .O_WREADY(wready),
        .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_GLOBAL_IRQ_EN(gie), .I_ACK_OVF(ack_ovf), .I_ACK_MATCH_A(ack_a), .I_ACK_MATCH_B(ack_b),
        .O_IRQ_OVF(irq_ovf), .O_IRQ_MATCH_A(irq_a), .O_IRQ_MATCH_B(irq_b),
        .I_EXT_COUNT_PIN(ext_pin), .O_WAVE_OUT_A(wave_a), .O_WAVE_OUT_A_OE(wave_a_oe),
        .O_WAVE_OUT_B(wave_b), .O_WAVE_OUT_B_OE(wave_b_oe)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task finish_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp)
            begin
                failures = failures + 1;
                $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task bus_hang;
        begin
            failures = failures + 1;
            $display("MISMATCH t=%0t bus answer timed out", $time);
            finish_test;
        end
    endtask

    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
        end
    endtask

    // write one register, hold each channel until taken
    task wr(input [11:0] ad, input [7:0] dt, input [1:0] er = `RESP_OKAY);
        integer t;
        reg     fin;
        begin
            fin = 1'b0;
            awaddr  <= ad;
            wdata   <= {24'h0, dt};
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            for (t = 0; t < 64 && !fin; t = t + 1)
            begin
                @(posedge clk);
                if (awvalid && awready)
                    awvalid <= 1'b0;
                if (wvalid && wready)
                    wvalid <= 1'b0;
                if (bvalid)
                begin
                    fin = 1'b1;
                    bready <= 1'b0;
                    check(bresp, er);
                end
            end
            if (!fin)
                bus_hang;
            @(posedge clk);
        end
    endtask

    task rd(input [11:0] ad, output [31:0] dt, input [1:0] er = `RESP_OKAY);
        integer t;
        reg     fin;
        begin
            fin = 1'b0;
            araddr  <= ad;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            for (t = 0; t < 64 && !fin; t = t + 1)
            begin
                @(posedge clk);
                if (arvalid && arready)
                    arvalid <= 1'b0;
                if (rvalid)
                begin
                    fin = 1'b1;
                    dt = rdata;
                    rready <= 1'b0;
                    check(rresp, er);
                end
            end
            if (!fin)
                bus_hang;
            @(posedge clk);
        end
    endtask

    task rc(input [11:0] ad, input [7:0] e);
        reg [31:0] v;
        begin
            rd(ad, v);
            check(v, {24'h0, e});
        end
    endtask

    initial
    begin
        failures = 0;
        n_checks = 0;
        rst = 1'b1;
        en = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {gie, ack_ovf, ack_a, ack_b, ext_pin} = 5'h0;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (a = 12'h000; a < 12'h01c; a = a + 12'h004)
            rc(a, 8'h00);
        rd(12'h01c, d, `RESP_SLVERR);
        wr(12'h020, 8'hff, `RESP_SLVERR);
        wr(`OFF_CTRL_B, 8'hff);
        rc(`OFF_CTRL_B, 8'h0f);
        wr(`OFF_CTRL_B, 8'h00);
        wr(`OFF_IRQ_MASK, 8'hff);
        rc(`OFF_IRQ_MASK, 8'h07);
        wr(`OFF_IRQ_FLAGS, 8'hff);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        wr(`OFF_COUNT, 8'ha5);
        rc(`OFF_COUNT, 8'ha5);
        wr(`OFF_CMP_A, 8'h5a);
        rc(`OFF_CMP_A, 8'h5a);
        wr(`OFF_CMP_B, 8'hc3);
        rc(`OFF_CMP_B, 8'hc3);
        $display("test register access done");
        for (k = 1; k < 6; k = k + 1)
        begin
            wr(`OFF_COUNT, 8'h00);
            wr(`OFF_CTRL_B, k[7:0]);
            cyc(16 * divs[k]);
            wr(`OFF_CTRL_B, 8'h00);
            rd(`OFF_COUNT, d);
            check(d >= 15 && d <= (k == 1 ? 26 : 18), 1);
            cyc(20);
            rc(`OFF_COUNT, d[7:0]);
        end
        wr(`OFF_COUNT, 8'h00);
        wr(`OFF_CTRL_B, 8'h01);
        en <= 1'b0;
        cyc(40);
        en <= 1'b1;
        wr(`OFF_CTRL_B, 8'h00);
        rd(`OFF_COUNT, d);
        check(d >= 4 && d <= 16, 1);
        for (k = 6; k < 8; k = k + 1)
        begin
            wr(`OFF_COUNT, 8'h00);
            wr(`OFF_CTRL_B, k[7:0]);
            repeat (3)
            begin
                ext_pin <= 1'b1;
                cyc(4);
                ext_pin <= 1'b0;
                cyc(4);
            end
            wr(`OFF_CTRL_B, 8'h00);
            rc(`OFF_COUNT, 8'h03);
        end
        $display("test clock select done");
        wr(`OFF_CMP_A, 8'h08);
        wr(`OFF_CMP_B, 8'h10);
        wr(`OFF_IRQ_MASK, 8'h07);
        wr(`OFF_COUNT, 8'h00);
        gie <= 1'b1;
        wr(`OFF_CTRL_B, 8'h01);
        cyc(20);
        wr(`OFF_CTRL_B, 8'h00);
        rc(`OFF_IRQ_FLAGS, 8'h06);
        check({irq_b, irq_a, irq_ovf}, 3'b110);
        ack_a <= 1'b1;
        cyc(1);
        ack_a <= 1'b0;
        cyc(1);
        check(irq_a, 1'b0);
        rc(`OFF_IRQ_FLAGS, 8'h04);
        wr(`OFF_IRQ_MASK, 8'h03);
        check(irq_b, 1'b0);
        wr(`OFF_IRQ_MASK, 8'h07);
        check(irq_b, 1'b1);
        gie <= 1'b0;
        cyc(2);
        check(irq_b, 1'b0);
        gie <= 1'b1;
        wr(`OFF_IRQ_FLAGS, 8'h00);
        rc(`OFF_IRQ_FLAGS, 8'h04);
        wr(`OFF_IRQ_FLAGS, 8'h04);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        wr(`OFF_CMP_B, 8'hfa);
        wr(`OFF_COUNT, 8'hf8);
        wr(`OFF_CTRL_B, 8'h01);
        cyc(4);
        wr(`OFF_CTRL_B, 8'h00);
        rd(`OFF_IRQ_FLAGS, d);
        check(d & 32'h5, 32'h5);
        check({irq_b, irq_ovf}, 2'b11);
        {ack_ovf, ack_a, ack_b} <= 3'b111;
        cyc(1);
        {ack_ovf, ack_a, ack_b} <= 3'b000;
        cyc(1);
        check({irq_b, irq_a, irq_ovf}, 3'b000);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        wr(`OFF_CMP_B, 8'h10);
        wr(`OFF_COUNT, 8'h10);
        wr(`OFF_CTRL_B, 8'h01);
        cyc(4);
        wr(`OFF_CTRL_B, 8'h00);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        $display("test compare and interrupts done");
        wr(`OFF_CMP_A, 8'h04);
        wr(`OFF_CTRL_A, 8'h02);
        wr(`OFF_COUNT, 8'h00);
        wr(`OFF_IRQ_FLAGS, 8'h07);
        wr(`OFF_CTRL_B, 8'h01);
        cyc(20);
        wr(`OFF_CTRL_B, 8'h00);
        rd(`OFF_COUNT, d);
        check(d <= 4, 1);
        rc(`OFF_IRQ_FLAGS, 8'h02);
        wr(`OFF_CTRL_A, 8'h01);
        wr(`OFF_IRQ_FLAGS, 8'h07);
        wr(`OFF_COUNT, 8'hfd);
        wr(`OFF_CTRL_B, 8'h01);
        cyc(8);
        wr(`OFF_CTRL_B, 8'h00);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        wr(`OFF_CTRL_B, 8'h01);
        cyc(260);
        wr(`OFF_CTRL_B, 8'h00);
        rd(`OFF_IRQ_FLAGS, d);
        check(d & 32'h1, 32'h1);
        wr(`OFF_IRQ_FLAGS, 8'h07);
        $display("test wave modes done");
        wr(`OFF_COUNT, 8'h33);
        for (k = 3; k > 0; k = k - 1)
        begin
            wr(`OFF_CTRL_A, {k[1:0], 6'h32});
            wr(`OFF_CTRL_B, 8'h80);
            cyc(2);
            check({wave_a_oe, wave_a}, {1'b1, k != 2});
        end
        wr(`OFF_CTRL_A, 8'h32);
        wr(`OFF_CTRL_B, 8'h40);
        cyc(2);
        check({wave_a_oe, wave_b_oe, wave_b}, 3'b011);
        rc(`OFF_IRQ_FLAGS, 8'h00);
        rc(`OFF_COUNT, 8'h33);
        wr(`OFF_CTRL_A, 8'hb3);
        wr(`OFF_CTRL_B, 8'h80);
        cyc(2);
        check(wave_a, 1'b1);
        $display("test forced compare done");
        finish_test;
    end
endmodule
